// ---- logic/mic_pkg.sv ----
// package: constants for the multicore interrupt controller shell
package mic_pkg;
  // ****************************************************************
  // address map (offsets from the base, 15-bit window)
  // ****************************************************************
  localparam int unsigned OFF_W       = 15;
  localparam logic [3:0]  RGN_RSVD    = 4'h0;
  localparam logic [3:0]  RGN_DIST    = 4'h1;
  localparam logic [3:0]  RGN_CPU_LO  = 4'h2;
  localparam logic [3:0]  RGN_CPU_HI  = 4'h3;
  localparam logic [3:0]  RGN_VCTL_C  = 4'h4;
  localparam logic [3:0]  RGN_VCTL_P  = 4'h5;
  localparam logic [3:0]  RGN_VCPU_LO = 4'h6;
  localparam logic [3:0]  RGN_VCPU_HI = 4'h7;
  localparam int unsigned RGN_MSB     = 14;
  localparam int unsigned RGN_LSB     = 12;
  localparam int unsigned VCPU_SEL_HI = 10;
  localparam int unsigned VCPU_SEL_LO = 9;
  localparam int unsigned BASE_W      = 25;
  // ****************************************************************
  // access sizes and target region codes
  // ****************************************************************
  typedef enum logic [1:0] {
    MIC_SZ_BYTE = 2'b00,
    MIC_SZ_HALF = 2'b01,
    MIC_SZ_WORD = 2'b10,
    MIC_SZ_DBL  = 2'b11
  } mic_size_t;
  typedef enum logic [2:0] {
    MIC_TGT_NONE = 3'b000,
    MIC_TGT_DIST = 3'b001,
    MIC_TGT_CPU  = 3'b010,
    MIC_TGT_VCTL = 3'b011,
    MIC_TGT_VCPU = 3'b100,
    MIC_TGT_EXT  = 3'b101
  } mic_tgt_t;
  // ****************************************************************
  // interrupt ids
  // ****************************************************************
  localparam int unsigned NUM_IDS   = 256;
  localparam int unsigned ID_W      = 8;
  localparam int unsigned NUM_SOFT_IDS = 16;
  localparam int unsigned ID_SPI0   = 32;
  localparam int unsigned MAX_SPI   = 224;
  localparam int unsigned SPI_STEP  = 32;
  localparam int unsigned ID_VMAINT = 25;
  localparam int unsigned ID_HYPTMR = 26;
  localparam int unsigned ID_VTMR   = 27;
  localparam int unsigned ID_FIQ    = 28;
  localparam int unsigned ID_STMR   = 29;
  localparam int unsigned ID_NSTMR  = 30;
  localparam int unsigned ID_IRQ    = 31;
  localparam int unsigned PRIO_W    = 5;
  localparam logic [PRIO_W-1:0] PRIO_IDLE = 5'h1f;
  localparam logic [ID_W-1:0]   ID_SPURIOUS = 8'hff;
  localparam int unsigned L2CTL_PRESENT_BIT = 23;
endpackage : mic_pkg

// ---- logic/mic_shell.sv ----
// module: decode, error responses and interrupt arbitration of the controller shell
`timescale 1ns/1ps
module mic_shell
  import mic_pkg::*;
#(
  parameter int unsigned NUM_CPU  = 4,
  parameter int unsigned NUM_SPI  = 224,
  parameter bit          CTRL_PRESENT = 1'b1
) (
  // clock, reset, controller rate enable
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  input  wire logic                          periph_clock_enable,
  // base strap
  input  wire logic [mic_pkg::BASE_W-1:0]    periph_base_addr,
  // register access request
  input  wire logic                          acc_valid,
  input  wire logic                          acc_write,
  input  wire logic                          acc_multi,
  input  wire logic                          acc_from_port,
  input  wire logic [1:0]                    acc_cpu,
  input  wire logic [mic_pkg::OFF_W-1:0]     acc_offset,
  input  wire mic_pkg::mic_size_t            acc_size,
  input  wire logic [31:0]                   acc_wdata,
  // access result
  output logic                               acc_abort_ff,
  output mic_pkg::mic_tgt_t                  acc_target_ff,
  output logic [1:0]                         acc_target_cpu_ff,
  output logic                               bus_error_irq_n_ff,
  // configuration readback
  output logic [mic_pkg::BASE_W-1:0]         config_base_addr_reg_ff,
  output logic                               l2ctl_ctrl_present_ff,
  // per-cpu private lines and control
  input  wire logic [NUM_CPU-1:0]            fast_irq_in_n,
  input  wire logic [NUM_CPU-1:0]            normal_irq_in_n,
  input  wire logic [NUM_CPU-1:0]            sec_timer_n,
  input  wire logic [NUM_CPU-1:0]            nsec_timer_n,
  input  wire logic [NUM_CPU-1:0]            virt_timer_n,
  input  wire logic [NUM_CPU-1:0]            hyp_timer_n,
  input  wire logic [NUM_CPU-1:0]            virt_maint,
  input  wire logic [NUM_CPU-1:0]            cpu_if_enable,
  input  wire logic [NUM_CPU-1:0]            soft_irq_generate_reg,
  input  wire logic [3:0]                    soft_irq_id,
  // shared lines and configuration
  input  wire logic [mic_pkg::MAX_SPI-1:0]   shared_irq_lines,
  input  wire logic [mic_pkg::MAX_SPI-1:0]   spi_edge_cfg,
  input  wire logic [mic_pkg::NUM_IDS*mic_pkg::PRIO_W-1:0] prio_flat,
  input  wire logic [mic_pkg::MAX_SPI*2-1:0] spi_cpu_target,
  input  wire logic [mic_pkg::NUM_IDS-1:0]   ack_clear,
  // requests to cores
  output logic [NUM_CPU-1:0]                 cpu_fast_req_ff,
  output logic [NUM_CPU-1:0]                 cpu_normal_req_ff,
  output logic [NUM_CPU*mic_pkg::ID_W-1:0]   cpu_best_id_ff,
  output logic [NUM_CPU*mic_pkg::PRIO_W-1:0] cpu_best_prio_ff
);
  import mic_pkg::*;

  localparam int unsigned SPI_N = (CTRL_PRESENT && NUM_SPI <= MAX_SPI &&
                                   (NUM_SPI % SPI_STEP) == 0) ? NUM_SPI : 0;

  // ****************************************************************
  // synchronisers for pin inputs
  // ****************************************************************
  localparam int unsigned PIN_W = 7*NUM_CPU + MAX_SPI;
  logic [PIN_W-1:0] pin_raw, pin_s1_ff, pin_s2_ff, nxt_pin_s1, nxt_pin_s2;
  assign pin_raw = {shared_irq_lines, virt_maint, hyp_timer_n, virt_timer_n,
                    nsec_timer_n, sec_timer_n, normal_irq_in_n, fast_irq_in_n};
  always_comb begin
    nxt_pin_s1 = pin_raw;
    nxt_pin_s2 = pin_s1_ff;
  end
  always_ff @(posedge ref_clk) begin
    pin_s1_ff <= nxt_pin_s1;
    pin_s2_ff <= nxt_pin_s2;
  end
  logic [NUM_CPU-1:0] fiq_n_s, irq_n_s, stmr_n_s, nstmr_n_s, vtmr_n_s, htmr_n_s, vmnt_s;
  logic [MAX_SPI-1:0] spi_s;
  assign {spi_s, vmnt_s, htmr_n_s, vtmr_n_s, nstmr_n_s, stmr_n_s, irq_n_s, fiq_n_s} = pin_s2_ff;

  // ****************************************************************
  // base capture and access decode
  // ****************************************************************
  logic              nxt_abort, nxt_err_n, nxt_present;
  logic [BASE_W-1:0] nxt_cfg_base;
  mic_tgt_t          nxt_tgt;
  logic [1:0]        nxt_tcpu;
  logic [3:0]        rgn;
  logic              bad_size, bad_rgn;
  assign rgn = {1'b0, acc_offset[RGN_MSB:RGN_LSB]};
  always_comb begin
    nxt_cfg_base = (!reset_n) ? periph_base_addr : config_base_addr_reg_ff;
    nxt_present = CTRL_PRESENT;
    nxt_tgt     = MIC_TGT_NONE;
    nxt_tcpu    = acc_cpu;
    bad_size    = (acc_size == MIC_SZ_HALF) || (acc_size == MIC_SZ_DBL) || acc_multi;
    bad_rgn     = 1'b0;
    case (rgn)
      RGN_RSVD:                nxt_tgt = MIC_TGT_NONE;
      RGN_DIST:                nxt_tgt = MIC_TGT_DIST;
      RGN_CPU_LO, RGN_CPU_HI:  nxt_tgt = MIC_TGT_CPU;
      RGN_VCTL_C:              nxt_tgt = MIC_TGT_VCTL;
      RGN_VCTL_P: begin
        nxt_tgt  = MIC_TGT_VCTL;
        nxt_tcpu = acc_offset[VCPU_SEL_HI:VCPU_SEL_LO];
      end
      RGN_VCPU_LO, RGN_VCPU_HI: nxt_tgt = MIC_TGT_VCPU;
      default:                 nxt_tgt = MIC_TGT_NONE;
    endcase
    bad_rgn = (nxt_tgt == MIC_TGT_NONE) || !CTRL_PRESENT;
    if (acc_from_port) begin
      nxt_tgt = MIC_TGT_EXT;
      bad_rgn = 1'b0;
      bad_size = 1'b0;
    end
    if (!acc_valid) nxt_tgt = MIC_TGT_NONE;
    nxt_abort = acc_valid && !acc_write && (bad_rgn || bad_size);
    nxt_err_n = !(acc_valid && acc_write && (bad_rgn || bad_size));
  end
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      acc_abort_ff         <= 1'b0;
      acc_target_ff        <= MIC_TGT_NONE;
      acc_target_cpu_ff    <= 2'h0;
      bus_error_irq_n_ff   <= 1'b1;
      l2ctl_ctrl_present_ff <= 1'b0;
    end else begin
      acc_abort_ff         <= nxt_abort;
      acc_target_ff        <= nxt_tgt;
      acc_target_cpu_ff    <= nxt_tcpu;
      bus_error_irq_n_ff   <= nxt_err_n;
      l2ctl_ctrl_present_ff <= nxt_present;
    end
    config_base_addr_reg_ff <= nxt_cfg_base;
  end

  // ****************************************************************
  // pending state per id, per cpu for ids below 32, updated on controller enable
  // ****************************************************************
  // private and soft pending is banked per cpu; shared pending is one copy
  logic [NUM_CPU-1:0][ID_SPI0-1:0] prv_pend_ff, nxt_prv_pend;
  logic [MAX_SPI-1:0] spi_pend_ff, nxt_spi_pend, spi_prev_ff, nxt_spi_prev;
  generate
    for (genvar c = 0; c < NUM_CPU; c++) begin : g_prv
      // clear goes first so a set in the same enable cycle wins
      always_comb begin
        nxt_prv_pend[c] = prv_pend_ff[c];
        if (periph_clock_enable) begin
          for (int i = 0; i < NUM_SOFT_IDS; i++) begin
            if (ack_clear[i]) nxt_prv_pend[c][i] = 1'b0;
            if (soft_irq_generate_reg[c] && soft_irq_id == i[3:0])
              nxt_prv_pend[c][i] = 1'b1;
          end
          nxt_prv_pend[c][ID_VMAINT] = vmnt_s[c];
          nxt_prv_pend[c][ID_HYPTMR] = !htmr_n_s[c];
          nxt_prv_pend[c][ID_VTMR]   = !vtmr_n_s[c];
          nxt_prv_pend[c][ID_STMR]   = !stmr_n_s[c];
          nxt_prv_pend[c][ID_NSTMR]  = !nstmr_n_s[c];
          nxt_prv_pend[c][ID_FIQ]    = cpu_if_enable[c] && !fiq_n_s[c];
          nxt_prv_pend[c][ID_IRQ]    = cpu_if_enable[c] && !irq_n_s[c];
        end
      end
    end
    for (genvar s = 0; s < MAX_SPI; s++) begin : g_spi
      // the previous level only moves on enable, so a line held for a
      // whole controller period is never missed as an edge
      always_comb begin
        nxt_spi_pend[s] = spi_pend_ff[s];
        nxt_spi_prev[s] = spi_prev_ff[s];
        if (periph_clock_enable) begin
          nxt_spi_prev[s] = spi_s[s];
          if (s >= SPI_N) nxt_spi_pend[s] = 1'b0;
          else if (spi_edge_cfg[s]) begin
            if (ack_clear[ID_SPI0+s]) nxt_spi_pend[s] = 1'b0;
            if (spi_s[s] && !spi_prev_ff[s]) nxt_spi_pend[s] = 1'b1;
          end else nxt_spi_pend[s] = spi_s[s];
        end
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prv_pend_ff <= '0;
      spi_pend_ff <= '0;
      spi_prev_ff <= '0;
    end else begin
      prv_pend_ff <= nxt_prv_pend;
      spi_pend_ff <= nxt_spi_pend;
      spi_prev_ff <= nxt_spi_prev;
    end
  end

  // ****************************************************************
  // per-cpu arbitration and request outputs
  // ****************************************************************
  // lower value wins, ties go to lower id; a full linear scan trades
  // area and depth for simplicity, though its result is registered on every ref_clk cycle
  logic [NUM_CPU-1:0] nxt_freq, nxt_nreq;
  logic [NUM_CPU*ID_W-1:0]   nxt_bid;
  logic [NUM_CPU*PRIO_W-1:0] nxt_bprio;
  generate
    for (genvar c = 0; c < NUM_CPU; c++) begin : g_cpu
      always_comb begin
        logic [ID_W-1:0]   bid;
        logic [PRIO_W-1:0] bp;
        logic              pend;
        pend = 1'b0;
        bid = ID_SPURIOUS;
        bp  = PRIO_IDLE;
        for (int i = 0; i < NUM_IDS; i++) begin
          if (i < ID_SPI0) pend = prv_pend_ff[c][i];
          else pend = spi_pend_ff[i-ID_SPI0] &&
                      (spi_cpu_target[(i-ID_SPI0)*2 +: 2] == 2'(c));
          if (pend && (bid == ID_SPURIOUS ||
                       prio_flat[i*PRIO_W +: PRIO_W] < bp)) begin
            bid = i[ID_W-1:0];
            bp  = prio_flat[i*PRIO_W +: PRIO_W];
          end
        end
        nxt_bid[c*ID_W +: ID_W]       = CTRL_PRESENT ? bid : ID_SPURIOUS;
        nxt_bprio[c*PRIO_W +: PRIO_W] = bp;
        // legacy bypass while the interface is off
        nxt_freq[c] = cpu_if_enable[c] ? 1'b0 : !fiq_n_s[c];
        nxt_nreq[c] = cpu_if_enable[c] ? (CTRL_PRESENT && bid != ID_SPURIOUS)
                                       : !irq_n_s[c];
      end
    end
  endgenerate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cpu_fast_req_ff   <= '0;
      cpu_normal_req_ff <= '0;
      cpu_best_id_ff    <= {NUM_CPU{ID_SPURIOUS}};
      cpu_best_prio_ff  <= {NUM_CPU{PRIO_IDLE}};
    end else begin
      cpu_fast_req_ff   <= nxt_freq;
      cpu_normal_req_ff <= nxt_nreq;
      cpu_best_id_ff    <= nxt_bid;
      cpu_best_prio_ff  <= nxt_bprio;
    end
  end
endmodule // mic_shell

// ---- dv/mic_shell_props.sv ----
// checker: access responses, strap capture and bypass of the controller shell
`timescale 1ns/1ps
module mic_shell_props
  import mic_pkg::*;
#(
  parameter int unsigned NUM_CPU     = 4,
  parameter bit          CTRL_PRESENT = 1'b1
) (
  input wire logic                       ref_clk,
  input wire logic                       reset_n,
  input wire logic                       acc_valid,
  input wire logic                       acc_write,
  input wire logic                       acc_multi,
  input wire logic                       acc_from_port,
  input wire logic [mic_pkg::OFF_W-1:0]  acc_offset,
  input wire mic_pkg::mic_size_t         acc_size,
  input wire logic                       acc_abort_ff,
  input wire mic_pkg::mic_tgt_t          acc_target_ff,
  input wire logic [1:0]                 acc_target_cpu_ff,
  input wire logic                       bus_error_irq_n_ff,
  input wire logic [mic_pkg::BASE_W-1:0] periph_base_addr,
  input wire logic [mic_pkg::BASE_W-1:0] config_base_addr_reg_ff,
  input wire logic                       l2ctl_ctrl_present_ff,
  input wire logic [NUM_CPU-1:0]         cpu_if_enable,
  input wire logic [NUM_CPU-1:0]         fast_irq_in_n,
  input wire logic [NUM_CPU-1:0]         cpu_fast_req_ff
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************************************
  // access classes
  // ****************************************************************
  sequence s_rd;
    acc_valid && !acc_write && !acc_from_port;
  endsequence
  sequence s_wr;
    acc_valid && acc_write && !acc_from_port;
  endsequence
  sequence s_rd_ok_word;
    s_rd ##0 (CTRL_PRESENT && !acc_multi &&
              (acc_size == MIC_SZ_WORD || acc_size == MIC_SZ_BYTE));
  endsequence
  property p_rsvd_rd;
    s_rd ##0 (acc_offset[14:12] == 3'h0) |=> acc_abort_ff;
  endproperty
  property p_rsvd_wr;
    s_wr ##0 (acc_offset[14:12] == 3'h0) |=> !bus_error_irq_n_ff;
  endproperty
  property p_half_rd;
    s_rd ##0 (acc_size == MIC_SZ_HALF) |=> acc_abort_ff;
  endproperty
  property p_multi_wr;
    s_wr ##0 acc_multi |=> !bus_error_irq_n_ff;
  endproperty
  property p_port;
    acc_valid && acc_from_port |=> acc_target_ff == MIC_TGT_EXT && !acc_abort_ff
      && bus_error_irq_n_ff;
  endproperty
  property p_dist;
    s_rd_ok_word ##0 (acc_offset[14:12] == 3'h1) |=> acc_target_ff == MIC_TGT_DIST;
  endproperty
  property p_vsel;
    s_rd_ok_word ##0 (acc_offset[14:12] == 3'h5) |=> acc_target_cpu_ff == $past(acc_offset[10:9]);
  endproperty
  // strap capture is judged while reset is low, so this one ignores reset
  property p_base;
    @(posedge ref_clk) disable iff (1'b0)
      !reset_n |=> config_base_addr_reg_ff == $past(periph_base_addr);
  endproperty
  property p_present;
    $past(reset_n) |-> l2ctl_ctrl_present_ff == CTRL_PRESENT;
  endproperty
  property p_bypass;
    (!cpu_if_enable[0] && !fast_irq_in_n[0]) [*6] |-> cpu_fast_req_ff[0];
  endproperty
  a_rsvd_rd:  assert property (p_rsvd_rd)  else $error("reserved read not aborted");
  a_rsvd_wr:  assert property (p_rsvd_wr)  else $error("reserved write no error");
  a_half_rd:  assert property (p_half_rd)  else $error("halfword read not aborted");
  a_multi_wr: assert property (p_multi_wr) else $error("multiple store no error");
  a_port:     assert property (p_port)     else $error("port access mishandled");
  a_dist:     assert property (p_dist)     else $error("distributor not decoded");
  a_vsel:     assert property (p_vsel)     else $error("per-cpu window cpu wrong");
  a_base:     assert property (p_base)     else $error("base strap not captured");
  a_present:  assert property (p_present)  else $error("present bit wrong");
  a_bypass:   assert property (p_bypass)   else $error("fast bypass missing");
endmodule // mic_shell_props

bind mic_shell mic_shell_props #(.NUM_CPU(NUM_CPU), .CTRL_PRESENT(CTRL_PRESENT)) u_props (
  .ref_clk(ref_clk), .reset_n(reset_n), .acc_valid(acc_valid), .acc_write(acc_write),
  .acc_multi(acc_multi), .acc_from_port(acc_from_port), .acc_offset(acc_offset),
  .acc_size(acc_size), .acc_abort_ff(acc_abort_ff), .acc_target_ff(acc_target_ff),
  .acc_target_cpu_ff(acc_target_cpu_ff), .bus_error_irq_n_ff(bus_error_irq_n_ff),
  .periph_base_addr(periph_base_addr), .config_base_addr_reg_ff(config_base_addr_reg_ff),
  .l2ctl_ctrl_present_ff(l2ctl_ctrl_present_ff), .cpu_if_enable(cpu_if_enable),
  .fast_irq_in_n(fast_irq_in_n), .cpu_fast_req_ff(cpu_fast_req_ff));

// ---- dv/mic_core_model.sv ----
// partner: core-side model making the rate enable and holding the base strap
`timescale 1ns/1ps
module mic_core_model
  import mic_pkg::*;
#(
  parameter int unsigned                RATIO    = 2,
  parameter logic [mic_pkg::BASE_W-1:0] BASE_VAL = 25'h0f1e2d3
) (
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  output logic                            periph_clock_enable,
  output logic [mic_pkg::BASE_W-1:0]      periph_base_addr,
  output logic [3:0]                      virt_normal_irq_n,
  output logic [3:0]                      virt_fast_irq_n
);
  int unsigned div_cnt;
  // strap never moves, even across resets
  assign periph_base_addr = BASE_VAL;
  // internal controller in use, so the virtual inputs stay released
  assign virt_normal_irq_n = 4'hf;
  assign virt_fast_irq_n   = 4'hf;
  always @(posedge ref_clk) begin
    if (!reset_n || div_cnt == RATIO - 1)
      div_cnt <= 0;
    else
      div_cnt <= div_cnt + 1;
  end
  // one enable cycle per RATIO ref_clk cycles, so an enable on every cycle when RATIO is 1
  assign periph_clock_enable = (div_cnt == RATIO - 1);
endmodule // mic_core_model

// ---- dv/multicore_interrupt_controller_shell_tb_top.sv ----
// testbench: decode, error responses and interrupt selection of the shell
`timescale 1ns/1ps
module multicore_interrupt_controller_shell_tb_top;
  import mic_pkg::*;
  localparam logic [24:0] STRAP = 25'h0f1e2d3;
  logic ref_clk = 0, reset_n = 0, acc_valid = 0, acc_write = 0, acc_multi = 0, acc_port = 0;
  logic [1:0] acc_cpu = 0;
  logic [14:0] acc_off = 0;
  mic_size_t acc_sz = MIC_SZ_WORD;
  logic [6:0] prv_in = 0;
  logic [3:0] if_en = 0, soft_req = 0, soft_id = 0;
  logic [223:0] shared = 0;
  logic [223:0] edge_cfg = 0;
  logic [1279:0] prio = {1280{1'b1}};
  logic [255:0] ack = 0;
  wire pce;
  wire [24:0] base;
  wire [3:0] vn_irq_n, vf_irq_n;
  logic abort, err_n, ctrl_p;
  mic_tgt_t tgt;
  logic [1:0] tcpu;
  logic [24:0] cbase;
  logic [3:0] freq, nreq;
  logic [31:0] best_id;
  logic [19:0] best_pr;
  int n_mismatch = 0, checks_done = 0;
  int ids[7] = '{26, 27, 28, 29, 30, 31, 25};
  initial forever #25 ref_clk = ~ref_clk;
  mic_core_model #(.RATIO(2), .BASE_VAL(STRAP)) u_model (.ref_clk(ref_clk),
    .reset_n(reset_n), .periph_clock_enable(pce), .periph_base_addr(base),
    .virt_normal_irq_n(vn_irq_n), .virt_fast_irq_n(vf_irq_n));
  mic_shell u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .periph_clock_enable(pce),
    .periph_base_addr(base), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_multi(acc_multi), .acc_from_port(acc_port), .acc_cpu(acc_cpu), .acc_offset(acc_off),
    .acc_size(acc_sz), .acc_wdata(32'h0), .acc_abort_ff(abort), .acc_target_ff(tgt),
    .acc_target_cpu_ff(tcpu), .bus_error_irq_n_ff(err_n), .config_base_addr_reg_ff(cbase),
    .l2ctl_ctrl_present_ff(ctrl_p), .fast_irq_in_n({3'h7, ~prv_in[2]}),
    .normal_irq_in_n({3'h7, ~prv_in[5]}), .sec_timer_n({3'h7, ~prv_in[3]}),
    .nsec_timer_n({3'h7, ~prv_in[4]}), .virt_timer_n({3'h7, ~prv_in[1]}),
    .hyp_timer_n({3'h7, ~prv_in[0]}), .virt_maint({3'h0, prv_in[6]}), .cpu_if_enable(if_en),
    .soft_irq_generate_reg(soft_req), .soft_irq_id(soft_id), .shared_irq_lines(shared),
    .spi_edge_cfg(edge_cfg), .prio_flat(prio), .spi_cpu_target(448'h0), .ack_clear(ack),
    .cpu_fast_req_ff(freq), .cpu_normal_req_ff(nreq), .cpu_best_id_ff(best_id),
    .cpu_best_prio_ff(best_pr));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // tg 7 means the target is not judged for a refused access
  task acc(input logic w, m, p, input logic [1:0] c, input logic [14:0] off,
           input mic_size_t sz, input logic ab, er, input logic [2:0] tg, input logic [1:0] tc);
    @(posedge ref_clk);
    {acc_valid, acc_write, acc_multi, acc_port} <= {1'b1, w, m, p};
    acc_cpu <= c;
    acc_off <= off;
    acc_sz <= sz;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    #1;
    chk("abort", abort, ab);
    chk("error_n", err_n, er);
    if (tg != 3'h7) chk("target", tgt, tg);
    if (tg != 3'h7) chk("target_cpu", tcpu, tc);
  endtask
  task t_access;
    acc(0, 0, 0, 0, 15'h0100, MIC_SZ_WORD, 1, 1, 3'h0, 0);
    acc(1, 0, 0, 0, 15'h0ffc, MIC_SZ_WORD, 0, 0, 3'h0, 0);
    acc(0, 0, 0, 0, 15'h1000, MIC_SZ_HALF, 1, 1, 3'h7, 0);
    acc(1, 0, 0, 0, 15'h2004, MIC_SZ_DBL, 0, 0, 3'h7, 0);
    acc(0, 1, 0, 0, 15'h1004, MIC_SZ_WORD, 1, 1, 3'h7, 0);
    acc(1, 1, 0, 0, 15'h1004, MIC_SZ_WORD, 0, 0, 3'h7, 0);
    acc(0, 0, 1, 0, 15'h0100, MIC_SZ_WORD, 0, 1, 3'h5, 0);
    acc(0, 0, 0, 1, 15'h1000, MIC_SZ_BYTE, 0, 1, 3'h1, 1);
    acc(1, 0, 0, 2, 15'h3ffc, MIC_SZ_WORD, 0, 1, 3'h2, 2);
    acc(0, 0, 0, 3, 15'h4000, MIC_SZ_WORD, 0, 1, 3'h3, 3);
    acc(0, 0, 0, 0, 15'h5400, MIC_SZ_WORD, 0, 1, 3'h3, 2);
    acc(1, 0, 0, 1, 15'h7ffc, MIC_SZ_WORD, 0, 1, 3'h4, 1);
  endtask
  task t_bypass;
    @(posedge ref_clk);
    prv_in <= 7'h24;
    repeat (8) @(posedge ref_clk);
    #1;
    chk("fast_req", freq[0], 1'b1);
    chk("normal_req", nreq[0], 1'b1);
    @(posedge ref_clk);
    prv_in <= 7'h0;
  endtask
  task t_ppi;
    @(posedge ref_clk);
    if_en[0] <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge ref_clk);
      prv_in <= 7'h1 << i;
      repeat (10) @(posedge ref_clk);
      #1;
      chk("private_id", best_id[7:0], ids[i]);
      @(posedge ref_clk);
      prv_in <= 7'h0;
      repeat (10) @(posedge ref_clk);
    end
  endtask
  // pulses span a whole controller period so an enable edge sees them
  task t_spi_sgi;
    @(posedge ref_clk);
    shared[1:0] <= 2'b11;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("spi_id", best_id[7:0], 8'h21);
    chk("spi_prio", best_pr[4:0], 5'h01);
    @(posedge ref_clk);
    {soft_id, soft_req} <= {4'h5, 4'h1};
    repeat (2) @(posedge ref_clk);
    soft_req <= 4'h0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("soft_id", best_id[7:0], 8'h05);
    @(posedge ref_clk);
    ack[5] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ack[5] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("after_ack", best_id[7:0], 8'h21);
    // an edge line keeps its pending after the pulse falls, until cleared
    @(posedge ref_clk);
    edge_cfg[2] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    shared[2] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    shared[2] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("spi_edge_id", best_id[7:0], 8'h22);
    @(posedge ref_clk);
    ack[34] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ack[34] <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("edge_cleared", best_id[7:0], 8'h21);
  endtask
  initial begin
    prio[25*5 +: 35] = 35'h0;
    prio[5*5 +: 5] = 5'h00;
    prio[32*5 +: 5] = 5'h03;
    prio[33*5 +: 5] = 5'h01;
    prio[34*5 +: 5] = 5'h00;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("cfg_base", cbase, STRAP);
    chk("ctrl_present", ctrl_p, 1'b1);
    chk("virt_tie", {vn_irq_n, vf_irq_n}, 8'hff);
    t_access();
    t_bypass();
    t_ppi();
    t_spi_sgi();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule // multicore_interrupt_controller_shell_tb_top
